/* File: lcac_top.sv */
// Configuration register bank for a four output LED driver with fade and animation control
// Overview of operation
// - Bits 7-4 fade code; 1..10 are 50ms steps
// - Code 0xF is 8s; 2s, 4s upper codes
// - Fade control bits 3-0 enable per-output ramping
// - Curve bits 7-4 select exponential dimming per output
// - Curve bits 3-0 enable autonomous animation per output
// - Two-bit field per output picks its sequencer
// - Sequencer zero has four two-bit pattern slots
// - All four registers reset to zero, read/write
// - A slot runs only when its enable set
`timescale 1ns/1ps
module lcac_top #(
	parameter int CYCLES_PER_MS = lcac_pkg::CYCLES_PER_MS_DEF,
	parameter int FADE_MS_CODE_B = 1000,
	parameter int FADE_MS_CODE_C = 2000,
	parameter int FADE_MS_CODE_D = 4000,
	parameter int FADE_MS_CODE_E = 6000
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register access from the serial host front end
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	// Slot enables of sequencer zero, held elsewhere
	input  wire logic [3:0]  seq0_slot_active,
	// Per output settings, bit n or field n serves output n
	output logic      [3:0]  ch_ramp_enable,
	output logic      [3:0]  ch_curve_exponential,
	output logic      [3:0]  ch_animation_enable,
	output logic      [7:0]  ch_sequencer_select,
	// Shared fade duration
	output logic      [13:0] fade_duration_ms,
	output logic      [29:0] fade_duration_cycles,
	// Sequencer zero slot program
	output logic      [7:0]  seq0_slot_pattern,
	output logic      [3:0]  seq0_slot_run
);
	logic [7:0]  fade_control_reg;
	logic [7:0]  curve_and_animation_select_reg;
	logic [7:0]  output_sequencer_map_reg;
	logic [7:0]  sequencer0_slot_patterns_reg;
	logic [3:0]  fade_duration_code;
	logic [13:0] fade_ms_next;

	assign fade_duration_code = fade_control_reg[lcac_pkg::FADE_CODE_LSB +: 4];

	// Register writes; unmapped addresses are ignored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fade_control_reg               <= lcac_pkg::REG_RESET;
			curve_and_animation_select_reg <= lcac_pkg::REG_RESET;
			output_sequencer_map_reg       <= lcac_pkg::REG_RESET;
			sequencer0_slot_patterns_reg   <= lcac_pkg::REG_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				lcac_pkg::FADE_CTRL_OFS:  fade_control_reg <= reg_wdata;
				lcac_pkg::CURVE_ANIM_OFS: curve_and_animation_select_reg <= reg_wdata;
				lcac_pkg::SEQ_MAP_OFS:    output_sequencer_map_reg <= reg_wdata;
				lcac_pkg::SEQ0_SLOT_OFS:  sequencer0_slot_patterns_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data registered one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				unique case (reg_addr)
					lcac_pkg::FADE_CTRL_OFS:  reg_rdata <= fade_control_reg;
					lcac_pkg::CURVE_ANIM_OFS: reg_rdata <= curve_and_animation_select_reg;
					lcac_pkg::SEQ_MAP_OFS:    reg_rdata <= output_sequencer_map_reg;
					lcac_pkg::SEQ0_SLOT_OFS:  reg_rdata <= sequencer0_slot_patterns_reg;
					default:                  reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Fade code to milliseconds; the middle upper codes are parameters since their values are uncertain
	always_comb begin
		if (fade_duration_code == lcac_pkg::FADE_CODE_OFF) begin
			fade_ms_next = 14'h0000;
		end else if (fade_duration_code <= lcac_pkg::FADE_CODE_LAST_STEP) begin
			fade_ms_next = 14'(fade_duration_code * lcac_pkg::FADE_STEP_MS);
		end else if (fade_duration_code == lcac_pkg::FADE_CODE_MAX) begin
			fade_ms_next = 14'(lcac_pkg::FADE_MAX_MS);
		end else begin
			unique case (fade_duration_code)
				4'hb:    fade_ms_next = 14'(FADE_MS_CODE_B);
				4'hc:    fade_ms_next = 14'(FADE_MS_CODE_C);
				4'hd:    fade_ms_next = 14'(FADE_MS_CODE_D);
				default: fade_ms_next = 14'(FADE_MS_CODE_E);
			endcase
		end
	end

	// Duration in ms and clock cycles, both from the same code so they never disagree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fade_duration_ms     <= 14'h0000;
			fade_duration_cycles <= 30'h00000000;
		end else begin
			fade_duration_ms     <= fade_ms_next;
			fade_duration_cycles <= 30'(fade_ms_next * CYCLES_PER_MS);
		end
	end

	// Sequencer zero slot program; a disabled slot is flagged not to run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seq0_slot_pattern <= 8'h00;
			seq0_slot_run     <= 4'h0;
		end else begin
			seq0_slot_pattern <= sequencer0_slot_patterns_reg;
			seq0_slot_run     <= seq0_slot_active;
		end
	end

	// One retiming stage per output
	for (genvar n = 0; n < 4; n++) begin : g_chan
		lcac_chan u_chan (
			.clk               (clk),
			.resetn            (resetn),
			.ramp_bit          (fade_control_reg[lcac_pkg::FADE_EN_LSB + n]),
			.exp_bit           (curve_and_animation_select_reg[lcac_pkg::CURVE_EXP_LSB + n]),
			.anim_bit          (curve_and_animation_select_reg[lcac_pkg::ANIM_EN_LSB + n]),
			.sel_bits          (output_sequencer_map_reg[n*lcac_pkg::SEL_WIDTH +: lcac_pkg::SEL_WIDTH]),
			.ramp_enable       (ch_ramp_enable[n]),
			.curve_exponential (ch_curve_exponential[n]),
			.animation_enable  (ch_animation_enable[n]),
			.sequencer_select  (ch_sequencer_select[n*lcac_pkg::SEL_WIDTH +: lcac_pkg::SEL_WIDTH])
		);
	end

	// Checks on the bank behaviour
	property p_fade_write;
		@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == lcac_pkg::FADE_CTRL_OFS |=> fade_control_reg == $past(reg_wdata);
	endproperty
	a_fade_write: assert property (p_fade_write) else $error("fade control write lost");

	property p_step_ms;
		@(posedge clk) disable iff (!resetn)
		(fade_duration_code != lcac_pkg::FADE_CODE_OFF && fade_duration_code <= lcac_pkg::FADE_CODE_LAST_STEP
			&& $stable(fade_duration_code))
			|-> fade_duration_ms == 14'(fade_duration_code * lcac_pkg::FADE_STEP_MS);
	endproperty
	a_step_ms: assert property (p_step_ms) else $error("fade step duration wrong");

	property p_max_ms;
		@(posedge clk) disable iff (!resetn)
		fade_duration_code == lcac_pkg::FADE_CODE_MAX |=> fade_duration_ms == 14'(lcac_pkg::FADE_MAX_MS);
	endproperty
	a_max_ms: assert property (p_max_ms) else $error("code f is not 8 s");

	property p_ramp;
		@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == lcac_pkg::FADE_CTRL_OFS |=> ##1 ch_ramp_enable == $past(reg_wdata[3:0], 2);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp enable not applied");

	property p_curve_anim;
		@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == lcac_pkg::CURVE_ANIM_OFS |=> ##1
			{ch_curve_exponential, ch_animation_enable} == $past(reg_wdata, 2);
	endproperty
	a_curve_anim: assert property (p_curve_anim) else $error("curve or animation bits wrong");

	property p_anim_off;
		@(posedge clk) disable iff (!resetn)
		!curve_and_animation_select_reg[0] |=> !ch_animation_enable[0];
	endproperty
	a_anim_off: assert property (p_anim_off) else $error("animation on while disabled");

	property p_map;
		@(posedge clk) disable iff (!resetn)
		ch_sequencer_select == $past(output_sequencer_map_reg);
	endproperty
	a_map: assert property (p_map) else $error("sequencer map mismatch");

	property p_slots;
		@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == lcac_pkg::SEQ0_SLOT_OFS |=> ##1 seq0_slot_pattern == $past(reg_wdata, 2);
	endproperty
	a_slots: assert property (p_slots) else $error("slot pattern not applied");

	property p_readback;
		@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == lcac_pkg::SEQ_MAP_OFS && !reg_wr |=> reg_rvalid && reg_rdata == output_sequencer_map_reg;
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	property p_slot_run;
		@(posedge clk) disable iff (!resetn)
		!seq0_slot_active[0] |=> !seq0_slot_run[0];
	endproperty
	a_slot_run: assert property (p_slot_run) else $error("disabled slot marked to run");

	// A valid pulse without a strobe would make the host take stale data
	property p_rvalid_pulse;
		@(posedge clk) disable iff (!resetn)
		!reg_rd |=> !reg_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without a read");

	property p_unmapped_write;
		@(posedge clk) disable iff (!resetn)
		reg_wr && !(reg_addr inside {[lcac_pkg::FADE_CTRL_OFS:lcac_pkg::SEQ0_SLOT_OFS]}) |=>
			$stable(fade_control_reg) && $stable(curve_and_animation_select_reg)
			&& $stable(output_sequencer_map_reg) && $stable(sequencer0_slot_patterns_reg);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a register");

	property p_unmapped_read;
		@(posedge clk) disable iff (!resetn)
		reg_rd && !(reg_addr inside {[lcac_pkg::FADE_CTRL_OFS:lcac_pkg::SEQ0_SLOT_OFS]}) |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	// Upper codes hold the long durations, whatever values they finally get
	property p_upper_ms;
		@(posedge clk) disable iff (!resetn)
		(fade_duration_code > lcac_pkg::FADE_CODE_LAST_STEP && $stable(fade_duration_code))
			|-> fade_duration_ms > 14'(lcac_pkg::FADE_CODE_LAST_STEP * lcac_pkg::FADE_STEP_MS);
	endproperty
	a_upper_ms: assert property (p_upper_ms) else $error("upper fade code below step range");

	c_long_fade: cover property (@(posedge clk) disable iff (!resetn) fade_duration_code == 4'hf ##1 fade_duration_ms == 14'd8000);
	c_all_anim: cover property (@(posedge clk) disable iff (!resetn) ch_animation_enable == 4'hf);
	c_read: cover property (@(posedge clk) disable iff (!resetn) reg_rd ##1 reg_rvalid && reg_rdata != 8'h00);
	c_slot_run: cover property (@(posedge clk) disable iff (!resetn) seq0_slot_run == 4'hf);
endmodule : lcac_top

/* File: lcac_pkg.sv */
// Register map, field layout and fade timing constants for the LED channel config bank
package lcac_pkg;
	// Register offsets
	localparam logic [7:0] FADE_CTRL_OFS  = 8'h03;
	localparam logic [7:0] CURVE_ANIM_OFS = 8'h04;
	localparam logic [7:0] SEQ_MAP_OFS    = 8'h05;
	localparam logic [7:0] SEQ0_SLOT_OFS  = 8'h06;
	// Reset value of every register
	localparam logic [7:0] REG_RESET      = 8'h00;
	// Field positions
	localparam int FADE_CODE_LSB  = 4;
	localparam int FADE_EN_LSB    = 0;
	localparam int CURVE_EXP_LSB  = 4;
	localparam int ANIM_EN_LSB    = 0;
	localparam int SEL_WIDTH      = 2;
	// Fade duration timing, in milliseconds
	localparam int FADE_STEP_MS   = 50;
	localparam int FADE_MAX_MS    = 8000;
	localparam logic [3:0] FADE_CODE_OFF  = 4'h0;
	localparam logic [3:0] FADE_CODE_LAST_STEP = 4'ha;
	localparam logic [3:0] FADE_CODE_MAX  = 4'hf;
	// Clock rate and the derived cycles per millisecond
	localparam int CLK_MHZ        = 125;
	localparam int CYCLES_PER_MS_DEF = CLK_MHZ * 1000;
	// Widths of the derived duration outputs
	localparam int MS_W           = 14;
	localparam int CYC_W          = 30;
endpackage : lcac_pkg

/* File: lcac_chan.sv */
// Per output channel configuration stage: registers the decoded settings of one output
`timescale 1ns/1ps
module lcac_chan (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Raw register bits for this output
	input  wire logic       ramp_bit,
	input  wire logic       exp_bit,
	input  wire logic       anim_bit,
	input  wire logic [1:0] sel_bits,
	// Registered settings for the channel datapath
	output logic            ramp_enable,
	output logic            curve_exponential,
	output logic            animation_enable,
	output logic [1:0]      sequencer_select
);
	// Settings are retimed so every consumer sees them change on the same edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ramp_enable       <= 1'b0;
			curve_exponential <= 1'b0;
			animation_enable  <= 1'b0;
			sequencer_select  <= 2'h0;
		end else begin
			ramp_enable       <= ramp_bit;
			curve_exponential <= exp_bit;
			animation_enable  <= anim_bit;
			sequencer_select  <= sel_bits;
		end
	end
endmodule : lcac_chan

/* File: lcac_host_model.sv */
// Host side model issuing single byte register writes and reads
`timescale 1ns/1ps
module lcac_host_model (
	// Clock
	input  wire logic       clk,
	// Register port towards the bank
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One byte write; address and data are inverted on release so stale values never pass
	task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		#1;
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
	endtask : write_byte
	// One byte read; answer is taken one cycle after the strobe
	task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic valid);
		@(posedge clk);
		#1;
		reg_addr = addr;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~addr;
		data = reg_rdata;
		valid = reg_rvalid;
	endtask : read_byte
endmodule : lcac_host_model

/* File: tb_top.sv */
// Self-checking testbench for the LED channel configuration bank
`timescale 1ns/1ps
module tb_top;
	localparam int CPM = 2;
	logic clk, resetn;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ch_sequencer_select, seq0_slot_pattern;
	logic reg_wr, reg_rd, reg_rvalid;
	logic [3:0] seq0_slot_active, ch_ramp_enable, ch_curve_exponential, ch_animation_enable, seq0_slot_run;
	logic [13:0] fade_duration_ms;
	logic [29:0] fade_duration_cycles;
	int err_count = 0;
	int comparisons = 0;
	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	lcac_top #(.CYCLES_PER_MS(CPM)) dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .seq0_slot_active(seq0_slot_active), .ch_ramp_enable(ch_ramp_enable),
		.ch_curve_exponential(ch_curve_exponential), .ch_animation_enable(ch_animation_enable),
		.ch_sequencer_select(ch_sequencer_select), .fade_duration_ms(fade_duration_ms),
		.fade_duration_cycles(fade_duration_cycles), .seq0_slot_pattern(seq0_slot_pattern),
		.seq0_slot_run(seq0_slot_run));
	lcac_host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// Single compare for every kind of value, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// Read a register and expect a value with the valid pulse
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		host_u.read_byte(addr, d, v);
		chk({31'h0, v}, 32'h1, "read valid");
		chk({24'h0, d}, {24'h0, exp}, "read data");
	endtask : rd_chk
	// Reset held for 6 cycles, then every register and output must be zero
	task automatic t_reset();
		@(posedge clk);
		#1;
		resetn = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk({20'h0, ch_ramp_enable, ch_curve_exponential, ch_animation_enable}, 32'h0, "enables at reset");
		chk({16'h0, ch_sequencer_select, seq0_slot_pattern}, 32'h0, "selects at reset");
		chk({18'h0, fade_duration_ms}, 32'h0, "fade ms after reset");
		chk({2'h0, fade_duration_cycles}, 32'h0, "fade cycles after reset");
		chk({27'h0, reg_rvalid, seq0_slot_run}, 32'h0, "valid and slot run at reset");
		for (int a = 3; a <= 6; a++) rd_chk(a[7:0], 8'h00);
	endtask : t_reset
	// Every firm fade code with a varying set of ramp enables
	task automatic t_fade();
		logic [3:0] code;
		int ms;
		for (int i = 0; i < 12; i++) begin
			code = (i == 11) ? 4'hf : i[3:0];
			ms = (code == 4'hf) ? lcac_pkg::FADE_MAX_MS : code * lcac_pkg::FADE_STEP_MS;
			host_u.write_byte(lcac_pkg::FADE_CTRL_OFS, {code, ~code});
			@(posedge clk);
			#1;
			chk({18'h0, fade_duration_ms}, ms, "fade ms");
			chk({2'h0, fade_duration_cycles}, ms * CPM, "fade cycles");
			chk({28'h0, ch_ramp_enable}, {28'h0, ~code}, "ramp enables");
			rd_chk(lcac_pkg::FADE_CTRL_OFS, {code, ~code});
		end
	endtask : t_fade
	// Curve, animation, sequencer map and slot patterns, plus an unmapped place
	task automatic t_fields();
		host_u.write_byte(lcac_pkg::CURVE_ANIM_OFS, 8'ha5);
		host_u.write_byte(lcac_pkg::SEQ_MAP_OFS, 8'he4);
		host_u.write_byte(lcac_pkg::SEQ0_SLOT_OFS, 8'h1b);
		host_u.write_byte(8'h07, 8'hff);
		chk({28'h0, ch_curve_exponential}, 32'ha, "exp curve");
		chk({28'h0, ch_animation_enable}, 32'h5, "animation");
		chk({24'h0, ch_sequencer_select}, 32'he4, "sequencer map");
		chk({24'h0, seq0_slot_pattern}, 32'h1b, "slot patterns");
		rd_chk(lcac_pkg::CURVE_ANIM_OFS, 8'ha5);
		rd_chk(lcac_pkg::SEQ_MAP_OFS, 8'he4);
		rd_chk(lcac_pkg::SEQ0_SLOT_OFS, 8'h1b);
		rd_chk(8'h07, 8'h00);
		host_u.write_byte(lcac_pkg::CURVE_ANIM_OFS, 8'h3f);
		@(posedge clk);
		#1;
		chk({24'h0, ch_curve_exponential, ch_animation_enable}, 32'h3f, "curve and animation rewrite");
	endtask : t_fields
	// Slot run follows the slot enables one cycle later
	task automatic t_slot_run();
		@(posedge clk);
		#1;
		seq0_slot_active = 4'h9;
		@(posedge clk);
		#1;
		chk({28'h0, seq0_slot_run}, 32'h9, "slot run");
		seq0_slot_active = 4'h6;
		@(posedge clk);
		#1;
		chk({28'h0, seq0_slot_run}, 32'h6, "slot run");
		seq0_slot_active = 4'hf;
		@(posedge clk);
		#1;
		chk({28'h0, seq0_slot_run}, 32'hf, "slot run");
	endtask : t_slot_run
	// Upper codes: only their range and the presence of 2 s and 4 s are firm
	task automatic t_upper();
		int ms;
		int hits;
		hits = 0;
		for (int c = 11; c <= 14; c++) begin
			host_u.write_byte(lcac_pkg::FADE_CTRL_OFS, {c[3:0], 4'h0});
			@(posedge clk);
			#1;
			ms = int'(fade_duration_ms);
			chk({31'h0, ms > 500 && ms < lcac_pkg::FADE_MAX_MS}, 32'h1, "upper fade range");
			chk({2'h0, fade_duration_cycles}, ms * CPM, "upper fade cycles");
			if (ms == 2000 || ms == 4000) hits++;
		end
		chk(hits, 2, "upper codes hold 2 s and 4 s");
	endtask : t_upper
	// Counts and verdict
	task automatic print_verdict();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	// Main sequence, second reset after the last test clears everything written
	initial begin
		resetn = 1'b0;
		seq0_slot_active = 4'h0;
		t_reset();
		t_fade();
		t_upper();
		t_fields();
		t_slot_run();
		t_reset();
		print_verdict();
	end
	// Watchdog well beyond the roughly 125 cycles the tests need
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule : tb_top
